// file: hw/cto_pkg.sv
/*
  Shared constants, settings layout and types of the cable thermal overload stage.
  Assumes harmonic magnitudes arrive per unit of rated line current, Q4.12, one sample frame per fixed period.
*/
// Behaviour
// - the replica is driven by the highest of the phase-current RMS values, each built from harmonic orders 1 up to 15
// - trip is asserted when the rise reaches 100 %, the level of service factor x ambient factor x rated current
// - start is asserted when the rise reaches the alarm limit, set 60 to 99 % in 1 % steps
// - below 0.3 x rated line current the time constant is the heating constant x the cooling coefficient
// - after power-up the thermal state starts at a rise of 70 % and moves toward the current's final value
// - the ambient factor is one if the forty-degree setting is 1.0, no sensor is fitted, or ambient is +40 C
// - start and trip release with reset ratio 0.95 applied in rise, that is 0.95 of the level in rise, about 0.975 of it in current
// - the heating constant is 2 to 180 min in 1 min steps and the rise tends to (I / Imax) squared
// - the rise is a persistent state between samples, where 1.2 stands for 120 %
// - the stage has one settings group, never switched
package cto_pkg;

  // ==================================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SERVICE = 8'h04;
  localparam logic [7:0] OFS_ALARM = 8'h08;
  localparam logic [7:0] OFS_TAU = 8'h0C;
  localparam logic [7:0] OFS_COOL = 8'h10;
  localparam logic [7:0] OFS_LIM40 = 8'h14;
  localparam logic [7:0] OFS_LIM70 = 8'h18;
  localparam logic [7:0] OFS_AMBIENT = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_THETA = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;

  // ==================================================================
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SENSOR_BIT = 1;
  localparam int EV_START_BIT = 0;
  localparam int EV_TRIP_BIT = 1;

  // ==================================================================
  // reset values and setting ranges (percent, minutes, tenths)
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [7:0] SERVICE_RST = 8'h64;
  localparam logic [7:0] SERVICE_MIN = 8'h0A;
  localparam logic [7:0] SERVICE_MAX = 8'hF0;
  localparam logic [7:0] ALARM_RST = 8'h50;
  localparam logic [7:0] ALARM_MIN = 8'h3C;
  localparam logic [7:0] ALARM_MAX = 8'h63;
  localparam logic [7:0] TAU_RST = 8'h1E;
  localparam logic [7:0] TAU_MIN = 8'h02;
  localparam logic [7:0] TAU_MAX = 8'hB4;
  localparam logic [7:0] COOL_RST = 8'h0A;
  localparam logic [7:0] COOL_MIN = 8'h0A;
  localparam logic [7:0] COOL_MAX = 8'h64;
  localparam logic [7:0] LIM40_RST = 8'h64;
  localparam logic [7:0] LIM40_MIN = 8'h46;
  localparam logic [7:0] LIM40_MAX = 8'h78;
  localparam logic [7:0] LIM70_RST = 8'h50;
  localparam logic [7:0] LIM70_MIN = 8'h32;
  localparam logic [7:0] LIM70_MAX = 8'h64;
  localparam logic [7:0] AMB_RST = 8'h28;
  localparam logic [7:0] AMB_REF = 8'h28;
  localparam logic [7:0] KT_MIN = 8'h0A;
  localparam logic [7:0] KT_MAX = 8'hC8;
  localparam logic [7:0] PCT_ONE = 8'h64;

  // ==================================================================
  // thermal state, Q8.32: 1.0 is a rise of 100 %
  localparam logic [39:0] THETA_ONE = 40'h01_0000_0000;
  localparam logic [39:0] THETA_INIT = 40'h00_B333_3333;
  localparam logic [6:0] RESET_RATIO_PCT = 7'h5F;
  localparam logic [35:0] COOL_I2_LIMIT = 36'h0_0017_0A3D;
  localparam logic [26:0] PCT2_SCALE = 27'h5F5_E100;
  localparam logic [15:0] INV_THIRTY = 16'h0889;

  // ==================================================================
  // timing: one model update per sample frame
  localparam int CLK_MHZ = 125;
  localparam int SAMPLE_PERIOD_US = 10000;
  localparam int SAMPLES_PER_MIN = 60_000_000 / SAMPLE_PERIOD_US;
  localparam logic [9:0] SAMPLES_PER_MIN_TENTH = 10'(SAMPLES_PER_MIN / 10);

  // ==================================================================
  // types
  typedef struct packed {
    logic [1:0] phase;
    logic [3:0] order;
    logic [15:0] mag;
  } cto_harm_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DIV_TGT = 5'h02,
    ST_DELTA = 5'h04,
    ST_DIV_STEP = 5'h08,
    ST_CMP = 5'h10
  } cto_state_t;

endpackage : cto_pkg

// file: hw/cto_div.sv
/*
  Iterative restoring divider, one quotient bit per enabled clock.
  Assumes start is only raised while busy is low; a zero divisor yields all ones.
*/
`timescale 1ns/100ps
`default_nettype none
module cto_div #(
  parameter int DW = 72,
  parameter int VW = 32
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [DW-1:0] dividend_in,
  input wire logic [VW-1:0] divisor_in,
  output logic busy_out,
  output logic done_out,
  output logic [DW-1:0] quot_out
);
  localparam int CW = $clog2(DW + 1);

  logic [VW-1:0] div_r;
  logic [VW-1:0] rem_r;
  logic [CW-1:0] cnt_r;
  logic [VW:0] rem_sh;
  logic take;

  // shift in next dividend bit, subtract when it fits
  assign rem_sh = {rem_r, quot_out[DW-1]};
  assign take = (rem_sh >= {1'b0, div_r});

  // ==================================================================
  // iteration
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_r <= '0;
      rem_r <= '0;
      cnt_r <= '0;
      quot_out <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        div_r <= divisor_in;
        rem_r <= '0;
        quot_out <= dividend_in;
        cnt_r <= CW'(DW);
        busy_out <= 1'b1;
      end else if (busy_out) begin
        rem_r <= take ? VW'(rem_sh - {1'b0, div_r}) : rem_sh[VW-1:0];
        quot_out <= {quot_out[DW-2:0], take};
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == CW'(1)) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule : cto_div
`default_nettype wire

// file: hw/cto_thermal_stage.sv
/*
  Cable thermal overload stage: harmonic RMS per phase, thermal replica, start and trip with hysteresis,
  settings and interrupt registers on a plain register port.
  Assumes harmonic data and frame strobes come from logic on core_clk_in, one frame per sample period.
*/
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module cto_thermal_stage (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire cto_pkg::cto_harm_t harm_in,
  input wire logic harm_valid_in,
  input wire logic frame_done_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic start_out,
  output logic trip_out,
  output logic irq_out
);

  // ==================================================================
  // helpers
  // limit a written setting into its legal range
  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp8

  // register select decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ==================================================================
  // declarations
  logic [1:0] ctrl_r;
  logic [7:0] service_r;
  logic [7:0] alarm_r;
  logic [7:0] tau_r;
  logic [7:0] cool_r;
  logic [7:0] lim40_r;
  logic [7:0] lim70_r;
  logic [7:0] amb_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_stat_nxt;
  logic [1:0] events;
  logic [31:0] rdata_nxt;

  logic [35:0] acc_r [3];
  logic [29:0] i2_r [3];
  logic frame_pend_r;
  logic [29:0] i2_max;
  logic cooling;
  logic cooling_r;

  cto_pkg::cto_state_t state_r;
  cto_pkg::cto_state_t state_nxt;
  logic [39:0] theta_r;
  logic [39:0] target_r;
  logic neg_r;
  logic [40:0] delta;
  logic [39:0] delta_abs;

  logic kt_one;
  logic signed [31:0] kt_dt;
  logic signed [31:0] kt_dl;
  logic signed [31:0] kt_mul;
  logic signed [31:0] kt_raw;
  logic [7:0] kt_pct;
  logic [15:0] imax_pct2;
  logic [31:0] imax_sq;
  logic [71:0] tgt_dividend;
  logic [24:0] tau_eff;

  logic div_start;
  logic [71:0] div_dividend;
  logic [31:0] div_divisor;
  logic div_busy;
  logic div_done;
  logic [71:0] div_quot;
  logic [39:0] quot_sat;

  logic [46:0] theta_x100;
  logic [53:0] theta_x10000;
  logic [46:0] trip_rel_lvl;
  logic [46:0] start_lvl;
  logic [53:0] start_rel_lvl;
  logic trip_nxt;
  logic start_nxt;
  logic trip_d_r;
  logic start_d_r;

  // ==================================================================
  // harmonic RMS, squared, per phase
  // orders 1..15 summed as squares; order 0 (dc) is left out
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_phase
      logic sel;
      logic [31:0] sq;
      logic [35:0] acc_sum;
      assign sel = harm_valid_in && (harm_in.phase == 2'(p)) && (harm_in.order != 4'h0);
      assign sq = harm_in.mag * harm_in.mag;
      assign acc_sum = acc_r[p] + (sel ? {4'h0, sq} : 36'h0_0000_0000);

      // accumulate, and latch with saturation at frame end
      always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          acc_r[p] <= '0;
          i2_r[p] <= '0;
        end else if (ce_in) begin
          if (frame_done_in) begin
            acc_r[p] <= '0;
            i2_r[p] <= (|acc_sum[35:30]) ? 30'h3FFF_FFFF : acc_sum[29:0];
          end else begin
            acc_r[p] <= acc_sum;
          end
        end
      end
    end
  endgenerate

  // hottest phase drives the replica
  assign i2_max = (i2_r[0] >= i2_r[1]) ? ((i2_r[0] >= i2_r[2]) ? i2_r[0] : i2_r[2])
                                       : ((i2_r[1] >= i2_r[2]) ? i2_r[1] : i2_r[2]);
  // below 0.3 x rated current means i2 below 0.09 in Q8.24
  assign cooling = ({6'h00, i2_max} < cto_pkg::COOL_I2_LIMIT);

  // ==================================================================
  // ambient correction factor, percent
  assign kt_one = !ctrl_r[cto_pkg::CTRL_SENSOR_BIT] || (lim40_r == cto_pkg::PCT_ONE)
                  || (amb_r == cto_pkg::AMB_REF);
  assign kt_dt = 32'(signed'(amb_r)) - 32'(signed'(cto_pkg::AMB_REF));
  assign kt_dl = 32'(signed'({1'b0, lim70_r})) - 32'(signed'({1'b0, lim40_r}));
  assign kt_mul = kt_dt * kt_dl * 32'(signed'({1'b0, cto_pkg::INV_THIRTY}));
  assign kt_raw = 32'(signed'({1'b0, cto_pkg::PCT_ONE})) + (kt_mul >>> 16);
  assign kt_pct = kt_one ? cto_pkg::PCT_ONE
                : (kt_raw < 32'(signed'({1'b0, cto_pkg::KT_MIN}))) ? cto_pkg::KT_MIN
                : (kt_raw > 32'(signed'({1'b0, cto_pkg::KT_MAX}))) ? cto_pkg::KT_MAX
                : kt_raw[7:0];

  // ==================================================================
  // trip current and target rise dividend
  // imax = service x ambient x rated; target = i2 / imax^2 in Q8.32
  assign imax_pct2 = service_r * kt_pct;
  assign imax_sq = imax_pct2 * imax_pct2;
  assign tgt_dividend = {64'(i2_max) * 64'(cto_pkg::PCT2_SCALE), 8'h00};
  // effective time constant in samples; cooling coefficient only when current is low
  assign tau_eff = tau_r * (cooling_r ? cool_r : cto_pkg::COOL_MIN) * cto_pkg::SAMPLES_PER_MIN_TENTH;

  // ==================================================================
  // shared divider: target first, then the step size
  assign div_start = (state_r == cto_pkg::ST_IDLE && frame_pend_r) || (state_r == cto_pkg::ST_DELTA);
  assign div_dividend = (state_r == cto_pkg::ST_DELTA) ? {32'h0000_0000, delta_abs} : tgt_dividend;
  assign div_divisor = (state_r == cto_pkg::ST_DELTA) ? {7'h00, tau_eff} : imax_sq;
  assign quot_sat = (|div_quot[71:40]) ? 40'hFF_FFFF_FFFF : div_quot[39:0];

  cto_div #(
    .DW(72),
    .VW(32)
  ) u_div (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .start_in(div_start),
    .dividend_in(div_dividend),
    .divisor_in(div_divisor),
    .busy_out(div_busy),
    .done_out(div_done),
    .quot_out(div_quot)
  );

  // distance from state to target
  assign delta = {1'b0, target_r} - {1'b0, theta_r};
  assign delta_abs = delta[40] ? 40'(-delta) : delta[39:0];

  // ==================================================================
  // update sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cto_pkg::ST_IDLE: begin
        if (frame_pend_r) begin
          state_nxt = cto_pkg::ST_DIV_TGT;
        end
      end
      cto_pkg::ST_DIV_TGT: begin
        if (div_done) begin
          state_nxt = cto_pkg::ST_DELTA;
        end
      end
      cto_pkg::ST_DELTA: begin
        state_nxt = cto_pkg::ST_DIV_STEP;
      end
      cto_pkg::ST_DIV_STEP: begin
        if (div_done) begin
          state_nxt = cto_pkg::ST_CMP;
        end
      end
      cto_pkg::ST_CMP: begin
        state_nxt = cto_pkg::ST_IDLE;
      end
    endcase
  end

  // state register, pending frame, cooling snapshot
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= cto_pkg::ST_IDLE;
      frame_pend_r <= 1'b0;
      cooling_r <= 1'b0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      if (frame_done_in) begin
        frame_pend_r <= 1'b1;
      end else if (state_r == cto_pkg::ST_IDLE) begin
        frame_pend_r <= 1'b0;
      end
      if (state_r == cto_pkg::ST_IDLE && frame_pend_r) begin
        cooling_r <= cooling;
      end
    end
  end

  // thermal memory and target
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      theta_r <= cto_pkg::THETA_INIT;
      target_r <= '0;
      neg_r <= 1'b0;
    end else if (ce_in) begin
      if (state_r == cto_pkg::ST_DIV_TGT && div_done) begin
        target_r <= quot_sat;
      end
      if (state_r == cto_pkg::ST_DELTA) begin
        neg_r <= delta[40];
      end
      if (state_r == cto_pkg::ST_DIV_STEP && div_done) begin
        theta_r <= neg_r ? theta_r - quot_sat : theta_r + quot_sat;
      end
    end
  end

  // ==================================================================
  // levels with hysteresis, all in rise units
  // a current ratio of sqrt(x) is a rise of x, so no square roots are needed
  assign theta_x100 = theta_r * 7'h64;
  assign theta_x10000 = theta_r * 14'h2710;
  assign trip_rel_lvl = {8'h00, cto_pkg::RESET_RATIO_PCT, 32'h0000_0000};
  assign start_lvl = {7'h00, alarm_r, 32'h0000_0000};
  assign start_rel_lvl = {22'(alarm_r) * 22'(cto_pkg::RESET_RATIO_PCT), 32'h0000_0000};

  always_comb begin
    trip_nxt = trip_out;
    start_nxt = start_out;
    if (!ctrl_r[cto_pkg::CTRL_EN_BIT]) begin
      trip_nxt = 1'b0;
      start_nxt = 1'b0;
    end else if (state_r == cto_pkg::ST_CMP) begin
      if (theta_r >= cto_pkg::THETA_ONE) begin
        trip_nxt = 1'b1;
      end else if (theta_x100 < trip_rel_lvl) begin
        trip_nxt = 1'b0;
      end
      if (theta_x100 >= start_lvl) begin
        start_nxt = 1'b1;
      end else if (theta_x10000 < start_rel_lvl) begin
        start_nxt = 1'b0;
      end
    end
  end

  // stage outputs
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      trip_out <= 1'b0;
      start_out <= 1'b0;
      trip_d_r <= 1'b0;
      start_d_r <= 1'b0;
    end else if (ce_in) begin
      trip_out <= trip_nxt;
      start_out <= start_nxt;
      trip_d_r <= trip_out;
      start_d_r <= start_out;
    end
  end

  // ==================================================================
  // interrupts: rising start and trip, write one to clear, set wins
  assign events = {trip_out & ~trip_d_r, start_out & ~start_d_r};
  assign irq_stat_nxt = (irq_stat_r & ~((reg_wr_in && hit(reg_addr_in, cto_pkg::OFS_IRQ_STAT))
                        ? reg_wdata_in[1:0] : 2'h0)) | events;
  assign irq_out = |(irq_stat_r & irq_mask_r);

  // ==================================================================
  // settings, one group only
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_r <= cto_pkg::CTRL_RST;
      service_r <= cto_pkg::SERVICE_RST;
      alarm_r <= cto_pkg::ALARM_RST;
      tau_r <= cto_pkg::TAU_RST;
      cool_r <= cto_pkg::COOL_RST;
      lim40_r <= cto_pkg::LIM40_RST;
      lim70_r <= cto_pkg::LIM70_RST;
      amb_r <= cto_pkg::AMB_RST;
      irq_mask_r <= 2'h0;
      irq_stat_r <= 2'h0;
    end else if (ce_in) begin
      irq_stat_r <= irq_stat_nxt;
      if (reg_wr_in) begin
        if (hit(reg_addr_in, cto_pkg::OFS_CTRL)) begin
          ctrl_r <= reg_wdata_in[1:0];
        end
        if (hit(reg_addr_in, cto_pkg::OFS_SERVICE)) begin
          service_r <= clamp8(reg_wdata_in[7:0], cto_pkg::SERVICE_MIN, cto_pkg::SERVICE_MAX);
        end
        if (hit(reg_addr_in, cto_pkg::OFS_ALARM)) begin
          alarm_r <= clamp8(reg_wdata_in[7:0], cto_pkg::ALARM_MIN, cto_pkg::ALARM_MAX);
        end
        if (hit(reg_addr_in, cto_pkg::OFS_TAU)) begin
          tau_r <= clamp8(reg_wdata_in[7:0], cto_pkg::TAU_MIN, cto_pkg::TAU_MAX);
        end
        if (hit(reg_addr_in, cto_pkg::OFS_COOL)) begin
          cool_r <= clamp8(reg_wdata_in[7:0], cto_pkg::COOL_MIN, cto_pkg::COOL_MAX);
        end
        if (hit(reg_addr_in, cto_pkg::OFS_LIM40)) begin
          lim40_r <= clamp8(reg_wdata_in[7:0], cto_pkg::LIM40_MIN, cto_pkg::LIM40_MAX);
        end
        if (hit(reg_addr_in, cto_pkg::OFS_LIM70)) begin
          lim70_r <= clamp8(reg_wdata_in[7:0], cto_pkg::LIM70_MIN, cto_pkg::LIM70_MAX);
        end
        if (hit(reg_addr_in, cto_pkg::OFS_AMBIENT)) begin
          amb_r <= reg_wdata_in[7:0];
        end
        if (hit(reg_addr_in, cto_pkg::OFS_IRQ_MASK)) begin
          irq_mask_r <= reg_wdata_in[1:0];
        end
      end
    end
  end

  // ==================================================================
  // read mux, data stand one cycle after the strobe
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (reg_addr_in)
      cto_pkg::OFS_CTRL: rdata_nxt = {30'h0000_0000, ctrl_r};
      cto_pkg::OFS_SERVICE: rdata_nxt = {24'h00_0000, service_r};
      cto_pkg::OFS_ALARM: rdata_nxt = {24'h00_0000, alarm_r};
      cto_pkg::OFS_TAU: rdata_nxt = {24'h00_0000, tau_r};
      cto_pkg::OFS_COOL: rdata_nxt = {24'h00_0000, cool_r};
      cto_pkg::OFS_LIM40: rdata_nxt = {24'h00_0000, lim40_r};
      cto_pkg::OFS_LIM70: rdata_nxt = {24'h00_0000, lim70_r};
      cto_pkg::OFS_AMBIENT: rdata_nxt = {24'h00_0000, amb_r};
      cto_pkg::OFS_STATUS: rdata_nxt = {27'h000_0000, kt_one, div_busy, cooling_r, trip_out, start_out};
      cto_pkg::OFS_THETA: rdata_nxt = theta_r[39:8];
      cto_pkg::OFS_IRQ_STAT: rdata_nxt = {30'h0000_0000, irq_stat_r};
      cto_pkg::OFS_IRQ_MASK: rdata_nxt = {30'h0000_0000, irq_mask_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data register; zero when no read
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      reg_rdata_out <= reg_rd_in ? rdata_nxt : 32'h0000_0000;
    end
  end

endmodule : cto_thermal_stage
`default_nettype wire

// file: tb/cto_stage_chk_sva.sv
/*
  Port assertions of the thermal overload stage.
  Assumes a bind from the bench top; sees top-level ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module cto_stage_chk (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic frame_done_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic irq_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  logic wr_ok;
  logic [9:0] quiet_r;
  // qualified register write
  assign wr_ok = ce_in && reg_wr_in;
  // ==================================================================
  // cycles since the last frame end or register write
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || frame_done_in || reg_wr_in) begin
      quiet_r <= 10'h000;
    end else if (quiet_r != 10'h3FF) begin
      quiet_r <= quiet_r + 10'h001;
    end
  end
  // ==================================================================
  // assertions
  chk_rdata_idle: assert property (ce_in && !reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data left standing");
  chk_reset_outs: assert property ($fell(sys_rst_in) |-> !start_out && !trip_out && !irq_out)
    else $error("outputs active after reset");
  chk_trip_start: assert property (trip_out |-> start_out)
    else $error("trip without start");
  chk_quiet_outs: assert property ($changed(start_out) || $changed(trip_out) |-> quiet_r < 10'h190)
    else $error("output moved without an update");
  chk_irq_cause: assert property ($rose(irq_out) |-> $past(reg_wr_in) ||
    ($past(start_out) && !$past(start_out, 2)) || ($past(trip_out) && !$past(trip_out, 2)))
    else $error("interrupt without event");
  chk_irq_clear: assert property (wr_ok && reg_addr_in == cto_pkg::OFS_IRQ_STAT && reg_wdata_in[1:0] == 2'h3
    && $stable(start_out) && $stable(trip_out) |=> !irq_out)
    else $error("interrupt survived clear");
  chk_mask_zero: assert property (wr_ok && reg_addr_in == cto_pkg::OFS_IRQ_MASK && reg_wdata_in[1:0] == 2'h0
    |=> !irq_out)
    else $error("interrupt with mask off");
  chk_enable_off: assert property (wr_ok && reg_addr_in == cto_pkg::OFS_CTRL && !reg_wdata_in[0]
    |-> ##[1:2] !start_out && !trip_out)
    else $error("outputs kept while disabled");
  cov_start: cover property ($rose(start_out));
  cov_trip: cover property ($rose(trip_out));
  cov_irq: cover property ($rose(irq_out));
endmodule : cto_stage_chk
`default_nettype wire

// file: tb/cto_meas_model.sv
/*
  Measurement source model: one harmonic word, then the frame end.
  Assumes a one-cycle send pulse from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module cto_meas_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic send_in,
  input wire cto_pkg::cto_harm_t word_in,
  output cto_pkg::cto_harm_t harm_out,
  output logic valid_out,
  output logic frame_out
);
  // word first, frame end next cycle; idle word toggles
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      harm_out <= '0;
      valid_out <= 1'b0;
      frame_out <= 1'b0;
    end else begin
      harm_out <= send_in ? word_in : ~harm_out;
      valid_out <= send_in;
      frame_out <= valid_out;
    end
  end
endmodule : cto_meas_model
`default_nettype wire

// file: tb/tb.sv
/*
  Self-checking bench of the thermal overload stage.
  Assumes the measurement model for frames; register port driven directly.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic send = 1'b0;
  logic hi = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] v;
  logic [31:0] t0;
  logic [31:0] rq;
  logic st, tr, irq, hv, fd;
  cto_pkg::cto_harm_t word = '0;
  cto_pkg::cto_harm_t harm;
  int mismatches = 0;
  int comparisons = 0;
  // rows: write flag, address, write byte, expected read
  logic [40:0] rows [27] = '{41'h0_00_00_000001, 41'h0_04_00_000064, 41'h0_08_00_000050, 41'h0_0C_00_00001E,
    41'h0_10_00_00000A, 41'h0_14_00_000064, 41'h0_18_00_000050, 41'h0_1C_00_000028, 41'h0_24_00_B33333,
    41'h0_28_00_000000, 41'h0_2C_00_000000, 41'h0_20_00_000010, 41'h0_40_00_000000, 41'h1_08_10_00003C,
    41'h1_08_70_000063, 41'h1_0C_01_000002, 41'h1_0C_FF_0000B4, 41'h1_04_05_00000A, 41'h1_00_03_000003,
    41'h1_14_78_000078, 41'h1_1C_14_000014, 41'h0_20_00_000000, 41'h1_1C_28_000028, 41'h0_20_00_000010,
    41'h1_00_01_000001, 41'h1_0C_02_000002, 41'h1_08_50_000050};
  cto_thermal_stage i_dut (.core_clk_in(clk), .sys_rst_in(rst), .ce_in(ce), .harm_in(harm),
    .harm_valid_in(hv), .frame_done_in(fd), .reg_addr_in(ad), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rq), .start_out(st), .trip_out(tr), .irq_out(irq));
  cto_meas_model i_meas (.clk_in(clk), .rst_in(rst), .send_in(send), .word_in(word), .harm_out(harm),
    .valid_out(hv), .frame_out(fd));
  // ==================================================================
  // clock and tasks
  always #4 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rq;
  endtask : rd_reg
  task automatic frame(input logic [3:0] o, input logic [1:0] p, input logic [15:0] m);
    @(posedge clk);
    word <= {p, o, m};
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (180) @(posedge clk);
    rd_reg(cto_pkg::OFS_STATUS, v);
  endtask : frame
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic conclude;
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // ==================================================================
  // main sequence
  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i][40]) wr_reg(rows[i][39:32], {24'h0, rows[i][31:24]});
      rd_reg(rows[i][39:32], v);
      if (rows[i][39:32] == cto_pkg::OFS_STATUS) v = v & 32'h10;
      check(v, {8'h0, rows[i][23:0]});
    end
    frame(4'h0, 2'h0, 16'h1000);
    check(v & 32'h4, 32'h4);
    rd_reg(cto_pkg::OFS_THETA, t0);
    check({31'h0, t0 < 32'h00B33333}, 32'h1);
    frame(4'hF, 2'h2, 16'h1000);
    check(v & 32'h4, 32'h0);
    rd_reg(cto_pkg::OFS_THETA, v);
    v = v - t0 + 32'h40 - (32'h64000000 - t0) / (2 * cto_pkg::SAMPLES_PER_MIN);
    check({31'h0, v < 32'h80}, 32'h1);
    for (int k = 0; k < 2; k++) begin
      frame(4'h1, 2'h1, 16'h04CC + 16'(k));
      check(v & 32'h4, k ? 32'h0 : 32'h4);
    end
    for (int n = 0; n < 60 && tr !== 1'b1; n++) begin
      frame(4'h1, 2'h0, 16'h1000);
      rd_reg(cto_pkg::OFS_THETA, v);
      check({31'h0, tr}, {31'h0, v >= 32'h01000000});
      check({31'h0, st}, {31'h0, hi || 64'(v) * 64'h64 >= 64'h50000000});
      if (st === 1'b1 && v >= 32'h00F33333 && !hi) begin
        wr_reg(cto_pkg::OFS_ALARM, 32'h63);
        hi = 1'b1;
      end
    end
    check({31'h0, tr}, 32'h1);
    rd_reg(cto_pkg::OFS_IRQ_STAT, v);
    check(v, 32'h3);
    check({31'h0, irq}, 32'h0);
    wr_reg(cto_pkg::OFS_IRQ_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr_reg(cto_pkg::OFS_IRQ_STAT, 32'h1);
    check({31'h0, irq}, 32'h0);
    rd_reg(cto_pkg::OFS_IRQ_STAT, v);
    check(v, 32'h2);
    wr_reg(cto_pkg::OFS_IRQ_MASK, 32'h3);
    check({31'h0, irq}, 32'h1);
    wr_reg(cto_pkg::OFS_IRQ_STAT, 32'h3);
    check({31'h0, irq}, 32'h0);
    wr_reg(cto_pkg::OFS_IRQ_MASK, 32'h0);
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(cto_pkg::OFS_ALARM, 32'h3C);
    ce <= 1'b1;
    rd_reg(cto_pkg::OFS_ALARM, v);
    check(v, 32'h63);
    wr_reg(cto_pkg::OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    check({30'h0, st, tr}, 32'h0);
    do_reset();
    rd_reg(cto_pkg::OFS_THETA, v);
    check(v, 32'h00B33333);
    check({30'h0, st, tr}, 32'h0);
    conclude();
  end
  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : tb
bind cto_thermal_stage cto_stage_chk i_chk (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
  .frame_done_in(frame_done_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .start_out(start_out), .trip_out(trip_out),
  .irq_out(irq_out));
`default_nettype wire
